// ### hdl/cdp_pkg.sv
// Shared constants, types and decode functions for the clock divider and phase configuration core.
package cdp_pkg;

  // Register byte offsets as carried in the low seven bits of the command code.
  localparam logic [6:0] OFS_MAKER    = 7'h00;  // Read-only reserved byte.
  localparam logic [6:0] OFS_G1_PHASE = 7'h01;  // Group one phase select byte.
  localparam logic [6:0] OFS_G1_DIV   = 7'h02;  // Group one divider control byte.
  localparam logic [6:0] OFS_G0_PHASE = 7'h03;  // Group zero phase select byte.
  localparam logic [6:0] OFS_G0_DIV   = 7'h04;  // Group zero divider control byte.
  localparam logic [6:0] OFS_CHIP     = 7'h05;  // Chip enable and upper output enables.
  localparam logic [6:0] OFS_LOW_EN   = 7'h06;  // Lower output enables.

  // Power-up values of the writable bytes.
  localparam logic [7:0] RST_G1_PHASE = 8'h20;
  localparam logic [7:0] RST_G1_DIV   = 8'h30;
  localparam logic [7:0] RST_G0_PHASE = 8'h00;
  localparam logic [7:0] RST_G0_DIV   = 8'h30;
  localparam logic [7:0] RST_CHIP     = 8'hff;
  localparam logic [7:0] RST_LOW_EN   = 8'hf0;

  // Writable bits of the chip byte; bit 6 is read-only and keeps its power-up one.
  localparam logic [7:0] WMASK_CHIP   = 8'hbf;
  localparam logic [7:0] WMASK_ALL    = 8'hff;

  // Read value of the reserved byte; the value is arbitrary.
  localparam logic [7:0] MAKER_RESERVED_VALUE = 8'h5a;

  // Field positions inside the bytes.
  localparam int PHASE_EN_BIT = 5;  // Phase adjust enable in the group one phase byte.
  localparam int PHASE_MSB    = 4;  // Top bit of a phase field.
  localparam int DIV_EN_BIT   = 5;  // Group divider enable.
  localparam int SEL_MSB      = 3;  // Top bit of a ratio select.
  localparam int CHIP_EN_BIT  = 7;  // Chip enable.
  localparam int HI_EN_MSB    = 5;  // Upper output enables occupy 5..0 of the chip byte.
  localparam int LO_EN_LSB    = 4;  // Lower output enables occupy 7..4 of their byte.
  localparam int LO_EN_MSB    = 7;
  localparam int CMD_BIT      = 7;  // Command marker bit of the command code.

  // Fixed upper five bits of the slave address; the low two come from pins.
  localparam logic [4:0] ADDR_FIXED = 5'h1a;

  // Serial slave states, one-hot.
  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_ADDR     = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_CMD      = 9'h008,
    ST_CMD_ACK  = 9'h010,
    ST_WDATA    = 9'h020,
    ST_WR_ACK   = 9'h040,
    ST_RDATA    = 9'h080,
    ST_RACK     = 9'h100
  } cdp_state_t;

  // Settings of one output group as seen by its post-divider.
  typedef struct packed {
    logic       en;     // Group divider enable.
    logic [3:0] sel;    // Ratio select code.
    logic [4:0] phase;  // Phase field.
  } cdp_grp_cfg_t;

  // Ratio select code to divide ratio; unused codes fall back to one.
  function automatic logic [6:0] ratio_of(input logic [3:0] sel);
    logic [6:0] r;
    r = 7'h01;
    case (sel)
      4'h0:    r = 7'h01;
      4'h1:    r = 7'h02;
      4'h2:    r = 7'h04;
      4'h3:    r = 7'h05;
      4'h4:    r = 7'h08;
      4'h5:    r = 7'h0a;
      4'h6:    r = 7'h10;
      4'h7:    r = 7'h14;
      4'h8:    r = 7'h20;
      4'h9:    r = 7'h28;
      4'ha:    r = 7'h50;
      default: r = 7'h01;
    endcase
    return r;
  endfunction

  // Five times a step index, for ratios whose step is five input cycles.
  function automatic logic [6:0] times_five(input logic [3:0] k);
    return {1'b0, k, 2'b00} + {3'h0, k};
  endfunction

  // Phase lead in input cycles: k steps of ratio/n cycles each.
  function automatic logic [6:0] lead_of(input logic [3:0] sel, input logic [4:0] ph);
    logic [6:0] l;
    l = 7'h00;
    case (sel)
      4'h1:    l = {6'h00, ph[0]};
      4'h2:    l = {5'h00, ph[1:0]};
      4'h4:    l = {4'h0, ph[2:0]};
      4'h6:    l = {3'h0, ph[3:0]};
      4'h8:    l = {2'h0, ph[4:0]};
      4'h5:    l = times_five({3'h0, ph[1]});
      4'h7:    l = times_five({2'h0, ph[2:1]});
      4'h9:    l = times_five({1'b0, ph[3:1]});
      4'ha:    l = times_five(ph[4:1]);
      default: l = 7'h00;
    endcase
    return l;
  endfunction

endpackage

// ### hdl/cdp_post_divider.sv
// Post-divider of one output group with phase preset on resynchronisation.
`timescale 1ns/1ps
module cdp_post_divider (
  input  wire logic                 clk_sys,  // Input clock.
  input  wire logic                 rstn,     // Asynchronous reset, active low.
  input  wire logic                 run,      // Chip and group enabled.
  input  wire logic                 resync,   // Reload the phase preset.
  input  cdp_pkg::cdp_grp_cfg_t     cfg,      // Ratio and phase settings.
  output logic                      level,    // Divided clock level.
  output logic                      tick      // One-cycle pulse at each period start.
);

  logic [6:0] cnt_r;    // Position inside the output period.
  logic [6:0] cnt_nxt;
  logic       level_r;
  logic       level_nxt;
  logic       tick_r;
  logic       tick_nxt;
  logic [6:0] ratio;    // Decoded divide ratio.
  logic [6:0] lead;     // Phase preset in input cycles.

  assign ratio = cdp_pkg::ratio_of(cfg.sel);
  assign lead  = cdp_pkg::lead_of(cfg.sel, cfg.phase);

  // Counter next value; a held group sits at zero so a later enable starts aligned.
  always_comb begin
    cnt_nxt = cnt_r;
    if (!run) begin
      cnt_nxt = 7'h00;
    end else if (resync) begin
      cnt_nxt = lead;
    end else if (cnt_r >= ratio - 7'h01) begin
      cnt_nxt = 7'h00;
    end else begin
      cnt_nxt = cnt_r + 7'h01;
    end
    // Ratio one passes the input rate, which this core shows as a standing high level.
    level_nxt = run && ((ratio == 7'h01) || (cnt_nxt < (ratio >> 1)));
    tick_nxt  = run && (cnt_nxt == 7'h00);
  end

  // Register the counter and its decoded outputs.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_r   <= 7'h00;
      level_r <= 1'b0;
      tick_r  <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      level_r <= level_nxt;
      tick_r  <= tick_nxt;
    end
  end

  assign level = level_r;
  assign tick  = tick_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // A resync loads the lead of the settings in force.
  property p_resync_lead;
    (run && resync) |=> (cnt_r == $past(lead));
  endproperty
  a_resync_lead: assert property (p_resync_lead) else $error("Divider did not load phase lead.");

  // Ratios one and five never take a phase lead.
  property p_no_phase;
    (run && resync && (cfg.sel == 4'h0 || cfg.sel == 4'h3)) |=> (cnt_r == 7'h00);
  endproperty
  a_no_phase: assert property (p_no_phase) else $error("Phase lead applied at ratio one or five.");

  // Ratio two with a stable setting alternates its counter between one and zero every cycle.
  property p_div2;
    (run && !resync && cfg.sel == 4'h1 && cnt_r == 7'h01) ##1 (run && !resync && $stable(cfg))
      |-> (cnt_r == 7'h00) ##1 (cnt_r == 7'h01 || !run || resync);
  endproperty
  a_div2: assert property (p_div2) else $error("Ratio two counter sequence wrong.");

endmodule // cdp_post_divider

// ### hdl/cdp_clock_distributor.sv
// Ten-output clock distributor core: two-wire register slave, configuration bytes and output gating.
`timescale 1ns/1ps
module cdp_clock_distributor (
  input  wire logic       clk_sys,               // Input clock.
  input  wire logic       rstn,                  // Power-on reset, asynchronous, active low.
  input  wire logic       scl_in,                // Serial clock pin.
  input  wire logic       sda_in,                // Serial data pin level.
  output logic            sda_out,               // Serial data drive value, always low.
  output logic            sda_oe,                // Serial data pulled low while high.
  input  wire logic [1:0] addr_pins,             // Low two slave address bits.
  output logic [9:0]      clock_out_true,        // True side of each output.
  output logic [9:0]      clock_out_complement,  // Complement side of each output.
  output logic [9:0]      output_driver_enable,  // High while an output drives.
  output logic            power_down             // High in the quiescent state.
);

  // Pin synchronisers; the first stage feeds only the second.
  logic       scl_meta_r, scl_sync_r, scl_prev_r;
  logic       sda_meta_r, sda_sync_r, sda_prev_r;
  logic [1:0] adr_meta_r, adr_sync_r;
  // Serial slave state.
  cdp_pkg::cdp_state_t state_r, state_nxt;
  logic [7:0] sh_r, sh_nxt;       // Shift register for both directions.
  logic [3:0] bits_r, bits_nxt;   // Bits of the current byte.
  logic [6:0] ofs_r, ofs_nxt;     // Register byte pointer.
  logic       rd_r, rd_nxt;       // Read requested by the address byte.
  logic       mack_r, mack_nxt;   // Master acknowledged the last read byte.
  logic       oe_r, oe_nxt;       // Registered data line pull-down.
  logic       wr_stb;             // A data byte is committed this cycle.
  // Register file and derived controls.
  logic [6:1][7:0] regs_r, regs_nxt;  // Writable bytes 1 to 6.
  logic            resync_r;          // Resync, one cycle after a write.
  logic [7:0]      rd_byte;           // Byte presented to a read.
  logic [7:0]      wmask;             // Writable bits of the addressed byte.
  cdp_pkg::cdp_grp_cfg_t g1_cfg, g0_cfg;
  logic            chip_en;
  logic [9:0]      drv_bits;          // Per-output enables from the bytes.
  logic [9:0]      gate;              // Combined enable per output.
  logic            g1_level, g0_level;
  // Output registers.
  logic [9:0] true_r, true_nxt;
  logic [9:0] comp_r, comp_nxt;
  logic [9:0] drv_r, drv_nxt;
  logic       pd_r, pd_nxt;
  // Edge and condition detection on synchronised pins.
  logic       scl_rise, scl_fall, start_det, stop_det;
  logic [6:0] dev_addr;
  // Two-stage synchronisers plus one history stage for edge detection.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scl_meta_r <= 1'b1;
      scl_sync_r <= 1'b1;
      scl_prev_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
      sda_prev_r <= 1'b1;
      adr_meta_r <= 2'h0;
      adr_sync_r <= 2'h0;
    end else begin
      scl_meta_r <= scl_in;
      scl_sync_r <= scl_meta_r;
      scl_prev_r <= scl_sync_r;
      sda_meta_r <= sda_in;
      sda_sync_r <= sda_meta_r;
      sda_prev_r <= sda_sync_r;
      adr_meta_r <= addr_pins;
      adr_sync_r <= adr_meta_r;
    end
  end
  assign scl_rise  = scl_sync_r && !scl_prev_r;
  assign scl_fall  = !scl_sync_r && scl_prev_r;
  assign start_det = scl_sync_r && scl_prev_r && sda_prev_r && !sda_sync_r;
  assign stop_det  = scl_sync_r && scl_prev_r && !sda_prev_r && sda_sync_r;
  assign dev_addr  = {cdp_pkg::ADDR_FIXED, adr_sync_r};
  // Read data mux; offsets past the last byte read as zero.
  always_comb begin
    rd_byte = 8'h00;
    if (ofs_r == cdp_pkg::OFS_MAKER) begin
      rd_byte = cdp_pkg::MAKER_RESERVED_VALUE;
    end else if (ofs_r <= cdp_pkg::OFS_LOW_EN) begin
      rd_byte = regs_r[ofs_r[2:0]];
    end
  end

  // Serial slave next state. Data changes only on falling clock edges so the
  // master always samples a settled line on the rising edge.
  always_comb begin
    state_nxt = state_r;
    sh_nxt    = sh_r;
    bits_nxt  = bits_r;
    ofs_nxt   = ofs_r;
    rd_nxt    = rd_r;
    mack_nxt  = mack_r;
    oe_nxt    = oe_r;
    wr_stb    = 1'b0;
    if (stop_det) begin
      state_nxt = cdp_pkg::ST_IDLE;
      oe_nxt    = 1'b0;
    end else if (start_det) begin
      // A repeated start keeps the pointer so a read can follow a command.
      state_nxt = cdp_pkg::ST_ADDR;
      bits_nxt  = 4'h0;
      oe_nxt    = 1'b0;
    end else begin
      unique case (state_r)
        cdp_pkg::ST_IDLE: begin
          oe_nxt = 1'b0;
        end
        cdp_pkg::ST_ADDR, cdp_pkg::ST_CMD, cdp_pkg::ST_WDATA: begin
          if (scl_rise) begin
            sh_nxt   = {sh_r[6:0], sda_sync_r};
            bits_nxt = bits_r + 4'h1;
          end else if (scl_fall && bits_r == 4'h8) begin
            bits_nxt = 4'h0;
            if (state_r == cdp_pkg::ST_ADDR) begin
              // Another slave's address leaves the line alone until the next start.
              if (sh_r[7:1] == dev_addr) begin
                rd_nxt    = sh_r[0];
                oe_nxt    = 1'b1;
                state_nxt = cdp_pkg::ST_ADDR_ACK;
              end else begin
                state_nxt = cdp_pkg::ST_IDLE;
              end
            end else if (state_r == cdp_pkg::ST_CMD) begin
              if (sh_r[cdp_pkg::CMD_BIT]) begin
                ofs_nxt   = sh_r[6:0];
                oe_nxt    = 1'b1;
                state_nxt = cdp_pkg::ST_CMD_ACK;
              end else begin
                state_nxt = cdp_pkg::ST_IDLE;
              end
            end else begin
              wr_stb    = 1'b1;
              ofs_nxt   = ofs_r + 7'h01;
              oe_nxt    = 1'b1;
              state_nxt = cdp_pkg::ST_WR_ACK;
            end
          end
        end
        cdp_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            bits_nxt = 4'h0;
            if (rd_r) begin
              sh_nxt    = rd_byte;
              ofs_nxt   = ofs_r + 7'h01;
              oe_nxt    = !rd_byte[7];
              state_nxt = cdp_pkg::ST_RDATA;
            end else begin
              oe_nxt    = 1'b0;
              state_nxt = cdp_pkg::ST_CMD;
            end
          end
        end
        cdp_pkg::ST_CMD_ACK, cdp_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            oe_nxt    = 1'b0;
            state_nxt = cdp_pkg::ST_WDATA;
          end
        end
        cdp_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (bits_r == 4'h7) begin
              bits_nxt  = 4'h0;
              oe_nxt    = 1'b0;
              state_nxt = cdp_pkg::ST_RACK;
            end else begin
              bits_nxt = bits_r + 4'h1;
              sh_nxt   = {sh_r[6:0], 1'b0};
              oe_nxt   = !sh_r[6];
            end
          end
        end
        cdp_pkg::ST_RACK: begin
          if (scl_rise) begin
            mack_nxt = !sda_sync_r;
          end else if (scl_fall) begin
            if (mack_r) begin
              sh_nxt    = rd_byte;
              ofs_nxt   = ofs_r + 7'h01;
              oe_nxt    = !rd_byte[7];
              state_nxt = cdp_pkg::ST_RDATA;
            end else begin
              state_nxt = cdp_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_nxt = cdp_pkg::ST_IDLE;
          oe_nxt    = 1'b0;
        end
      endcase
    end
  end
  // Register file next value; the reserved byte and offsets past byte 6 ignore writes.
  always_comb begin
    regs_nxt = regs_r;
    wmask    = (ofs_r == cdp_pkg::OFS_CHIP) ? cdp_pkg::WMASK_CHIP : cdp_pkg::WMASK_ALL;
    if (wr_stb && ofs_r >= cdp_pkg::OFS_G1_PHASE && ofs_r <= cdp_pkg::OFS_LOW_EN) begin
      regs_nxt[ofs_r[2:0]] = (sh_r & wmask) | (regs_r[ofs_r[2:0]] & ~wmask);
    end
  end
  // Serial and register state; resync trails the write so dividers see new settings.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r  <= cdp_pkg::ST_IDLE;
      sh_r     <= 8'h00;
      bits_r   <= 4'h0;
      ofs_r    <= 7'h00;
      rd_r     <= 1'b0;
      mack_r   <= 1'b0;
      oe_r     <= 1'b0;
      regs_r   <= {cdp_pkg::RST_LOW_EN, cdp_pkg::RST_CHIP, cdp_pkg::RST_G0_DIV,
                   cdp_pkg::RST_G0_PHASE, cdp_pkg::RST_G1_DIV, cdp_pkg::RST_G1_PHASE};
      resync_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      sh_r     <= sh_nxt;
      bits_r   <= bits_nxt;
      ofs_r    <= ofs_nxt;
      rd_r     <= rd_nxt;
      mack_r   <= mack_nxt;
      oe_r     <= oe_nxt;
      regs_r   <= regs_nxt;
      resync_r <= wr_stb;
    end
  end
  // Field extraction for the two groups and the enables.
  assign g1_cfg   = '{en:    regs_r[cdp_pkg::OFS_G1_DIV][cdp_pkg::DIV_EN_BIT],
                      sel:   regs_r[cdp_pkg::OFS_G1_DIV][cdp_pkg::SEL_MSB:0],
                      phase: regs_r[cdp_pkg::OFS_G1_PHASE][cdp_pkg::PHASE_MSB:0]};
  assign g0_cfg   = '{en:    regs_r[cdp_pkg::OFS_G0_DIV][cdp_pkg::DIV_EN_BIT],
                      sel:   regs_r[cdp_pkg::OFS_G0_DIV][cdp_pkg::SEL_MSB:0],
                      phase: regs_r[cdp_pkg::OFS_G0_PHASE][cdp_pkg::PHASE_MSB:0]};
  assign chip_en  = regs_r[cdp_pkg::OFS_CHIP][cdp_pkg::CHIP_EN_BIT];
  assign drv_bits = {regs_r[cdp_pkg::OFS_CHIP][cdp_pkg::HI_EN_MSB:0],
                     regs_r[cdp_pkg::OFS_LOW_EN][cdp_pkg::LO_EN_MSB:cdp_pkg::LO_EN_LSB]};
  assign gate     = drv_bits & {{5{g1_cfg.en}}, {5{g0_cfg.en}}} & {10{chip_en}};
  // Group one post-divider, outputs 9 to 5.
  cdp_post_divider u_group_one_post_divider (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .run     (chip_en && g1_cfg.en),
    .resync  (resync_r),
    .cfg     (g1_cfg),
    .level   (g1_level),
    .tick    ()
  );
  // Group zero post-divider, outputs 4 to 0.
  cdp_post_divider u_group_zero_post_divider (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .run     (chip_en && g0_cfg.en),
    .resync  (resync_r),
    .cfg     (g0_cfg),
    .level   (g0_level),
    .tick    ()
  );
  // Output drive: a disabled output floats and its termination pulls both sides high.
  always_comb begin
    drv_nxt  = gate;
    true_nxt = ({{5{g1_level}}, {5{g0_level}}} & gate) | ~gate;
    comp_nxt = ({{5{!g1_level}}, {5{!g0_level}}} & gate) | ~gate;
    pd_nxt   = !chip_en;
  end
  // Output registers.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      drv_r  <= 10'h000;
      true_r <= 10'h3ff;
      comp_r <= 10'h3ff;
      pd_r   <= 1'b0;
    end else begin
      drv_r  <= drv_nxt;
      true_r <= true_nxt;
      comp_r <= comp_nxt;
      pd_r   <= pd_nxt;
    end
  end
  assign sda_out              = 1'b0;
  assign sda_oe               = oe_r;
  assign clock_out_true       = true_r;
  assign clock_out_complement = comp_r;
  assign output_driver_enable = drv_r;
  assign power_down           = pd_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Disabled groups float their five outputs.
  property p_g1_off;
    !g1_cfg.en |=> (output_driver_enable[9:5] == 5'h00) && (clock_out_true[9:5] == 5'h1f);
  endproperty
  a_g1_off: assert property (p_g1_off) else $error("Group one outputs not disabled.");
  property p_g0_off;
    !g0_cfg.en |=> (output_driver_enable[4:0] == 5'h00) && (clock_out_complement[4:0] == 5'h1f);
  endproperty
  a_g0_off: assert property (p_g0_off) else $error("Group zero outputs not disabled.");
  property p_power_down;
    !chip_en |=> power_down && (output_driver_enable == 10'h000);
  endproperty
  a_power_down: assert property (p_power_down) else $error("Chip disable did not power down.");
  property p_out_bits;
    (chip_en && g1_cfg.en && g0_cfg.en && !drv_bits[9] && !drv_bits[0])
      |=> !output_driver_enable[9] && !output_driver_enable[0];
  endproperty
  a_out_bits: assert property (p_out_bits) else $error("Single output disable ignored.");
  // A committed byte lands in the register, then the dividers resync.
  sequence s_div_write;
    wr_stb && ofs_r == cdp_pkg::OFS_G1_DIV;
  endsequence
  property p_write_resync;
    s_div_write |=> (regs_r[cdp_pkg::OFS_G1_DIV] == $past(sh_r)) && resync_r;
  endproperty
  a_write_resync: assert property (p_write_resync) else $error("Write not stored or not resynced.");
  // A command without its marker bit is refused.
  sequence s_cmd_end;
    state_r == cdp_pkg::ST_CMD && !start_det && !stop_det && scl_fall && bits_r == 4'h8;
  endsequence
  property p_cmd_marker;
    s_cmd_end |=> (sh_r[cdp_pkg::CMD_BIT] ? (state_r == cdp_pkg::ST_CMD_ACK && sda_oe)
                                          : (state_r == cdp_pkg::ST_IDLE && !sda_oe));
  endproperty
  a_cmd_marker: assert property (p_cmd_marker) else $error("Command marker handling wrong.");
endmodule // cdp_clock_distributor

// ### tb/cdp_i2c_master.sv
// Two-wire bus master model that programs and reads the device.
`timescale 1ns/1ps
module cdp_i2c_master (
  input  wire logic       clk_sys,  // Bench clock.
  input  wire logic       sda_oe,   // Device pulls data low.
  output logic            scl,      // Serial clock, idle high.
  output logic            sda,      // Resolved data wire.
  output logic            rd_vld,   // High for one cycle per byte read.
  output logic [7:0]      rd_byte   // Byte just read.
);
  logic m_low;  // Master pulls data low.
  // The pull-up wins only while nobody drives, as on the real wire.
  assign sda = ~(m_low | sda_oe);
  initial begin
    scl = 1'b1;
    m_low = 1'b0;
    rd_vld = 1'b0;
    rd_byte = 8'h00;
  end
  // Sets both lines, then holds them for n clocks.
  task automatic set(input logic lo, input logic c, input int n);
    m_low = lo;
    scl = c;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Data moves only mid-low, so a bit is never taken for a start or stop.
  task automatic bit_io(input logic b, output logic r);
    set(~b, 1'b0, 16);
    set(~b, 1'b1, 20);
    r = sda;
    set(~b, 1'b0, 4);
  endtask
  task automatic start();
    set(1'b0, 1'b0, 16);
    set(1'b0, 1'b1, 20);
    set(1'b1, 1'b1, 20);
    set(1'b1, 1'b0, 4);
  endtask
  task automatic stop();
    set(1'b1, 1'b0, 16);
    set(1'b1, 1'b1, 20);
    set(1'b0, 1'b1, 40);
  endtask
  task automatic wr(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd(input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, rd_byte[i]);
    bit_io(last, r);
    rd_vld = 1'b1;
    set(m_low, scl, 1);
    rd_vld = 1'b0;
  endtask
endmodule  // cdp_i2c_master

// ### tb/cdp_clock_distributor_tb.sv
// Self-checking bench for the clock distributor core.
`timescale 1ns/1ps
module cdp_clock_distributor_tb;
  logic       clk_sys, rstn, scl, sda, sda_oe, pd, rd_vld, a, g0, g1, so;  // Single-bit lines.
  logic [1:0] ap;               // Address pin setting.
  logic [7:0] rd_byte, b5, b6;  // Read byte and chosen enable bytes.
  logic [9:0] yt, yc, de, ee;   // Output pairs, driver enables and the enables expected.
  logic [7:0] exp_q[$];         // Expected read bytes, oldest first.
  int         error_cnt, check_count, p, d, ph, rt, n, w;
  localparam int RT[11] = '{1, 2, 4, 5, 8, 10, 16, 20, 32, 40, 80};  // Ratio per code.
  cdp_clock_distributor uut (.clk_sys(clk_sys), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(so),
    .sda_oe(sda_oe), .addr_pins(ap), .clock_out_true(yt), .clock_out_complement(yc),
    .output_driver_enable(de), .power_down(pd));
  cdp_i2c_master m (.clk_sys(clk_sys), .sda_oe(sda_oe), .scl(scl), .sda(sda), .rd_vld(rd_vld),
    .rd_byte(rd_byte));
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic hdr(input logic [6:0] ofs, input logic ok);
    m.start();
    m.wr({cdp_pkg::ADDR_FIXED, ap, 1'b0}, a);
    chk("addr ack", 10'h1, 10'(a));
    m.wr({ok, ofs}, a);
    chk("cmd ack", 10'(ok), 10'(a));
  endtask
  task automatic wb(input logic [6:0] ofs, input logic [7:0] v);
    hdr(ofs, 1'b1);
    m.wr(v, a);
    chk("data ack", 10'h1, 10'(a));
    m.stop();
  endtask
  task automatic ww(input logic [6:0] ofs, input logic [31:0] v);
    hdr(ofs, 1'b1);
    for (int i = 3; i >= 0; i--) begin
      m.wr(v[8*i +: 8], a);
      chk("data ack", 10'h1, 10'(a));
    end
    m.stop();
  endtask
  // Reads n bytes; the monitor below compares each against the queue.
  task automatic rb(input logic [6:0] ofs, input int n);
    hdr(ofs, 1'b1);
    m.start();
    m.wr({cdp_pkg::ADDR_FIXED, ap, 1'b1}, a);
    for (int i = 0; i < n; i++) m.rd(i == n - 1);
    m.stop();
  endtask
  // Period of output 9 and delay from its rise to the next rise of output 0.
  task automatic meas(output int p, output int d);
    int a9, b9, z0;
    logic [9:0] pv;
    a9 = -1;
    b9 = -1;
    z0 = -1;
    pv = yt;
    for (int t = 0; t < 400; t++) begin
      @(posedge clk_sys);
      #2;
      if (yt[9] && !pv[9] && a9 >= 0 && b9 < 0) b9 = t;
      if (yt[9] && !pv[9] && a9 < 0) a9 = t;
      if (yt[0] && !pv[0] && a9 >= 0 && z0 < 0) z0 = t;
      pv = yt;
    end
    p = b9 - a9;
    d = z0 - a9;
  endtask
  always @(posedge rd_vld) chk("read", 10'(exp_q.pop_front()), 10'(rd_byte));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Cuts a hang short; the whole run needs well under this span.
  initial begin
    #900000;
    error_cnt++;
    stop_test();
  end
  initial begin
    rstn = 1'b0;
    error_cnt = 0;
    check_count = 0;
    void'($urandom(73));
    ap = 2'($urandom);
    repeat (16) @(posedge clk_sys);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk("enables", 10'h3ff, de);
    chk("power", 10'h0, 10'(pd));
    chk("sda drive", 10'h0, 10'(so));
    exp_q = '{cdp_pkg::MAKER_RESERVED_VALUE, 8'h20, 8'h30, 8'h00, 8'h30, 8'hff, 8'hf0, 8'h00};
    rb(7'h00, 8);
    wb(7'h00, 8'ha5);
    exp_q.push_back(cdp_pkg::MAKER_RESERVED_VALUE);
    rb(7'h00, 1);
    hdr(7'h02, 1'b0);
    m.stop();
    // Both groups share a ratio; only group one gets a phase field.
    for (int s = 0; s < 11; s++) begin
      ph = $urandom % 32;
      ww(7'h01, {3'b001, 5'(ph), 4'h3, 4'(s), 8'h00, 4'h3, 4'(s)});
      meas(p, d);
      rt = RT[s];
      n = (rt % 5 == 0) ? rt / 5 : rt;
      w = (rt % 5 == 0) ? 5 * ((ph >> 1) % n) : ph % n;
      if (s == 0) chk("ratio one", 10'h3e0, {yt[9:5], yc[9:5]});
      else begin
        chk("period", 10'(rt), 10'(p));
        chk("lead", 10'(w), 10'(d));
      end
    end
    for (int i = 0; i < 4; i++) begin
      {g1, g0} = 2'(i + 1);
      // The pass with both groups on always parks outputs 9 and 0 by their own bits.
      b5 = {i != 3, 7'($urandom)} & ~{2'b00, i == 2, 5'h00};
      b6 = 8'($urandom) & ~{3'b000, i == 2, 4'h0};
      ww(7'h02, {2'b00, g1, 5'h10, 8'h00, 2'b00, g0, 5'h10, b5});
      wb(7'h06, b6);
      ee = b5[7] ? {{5{g1}}, {5{g0}}} & {b5[5:0], b6[7:4]} : 10'h0;
      chk("enables", ee, de);
      chk("power", {9'h000, !b5[7]}, 10'(pd));
      chk("parked", ~ee, yt & yc & ~ee);
      exp_q = '{b5 | 8'h40, b6};
      rb(7'h05, 2);
    end
    stop_test();
  end
endmodule  // cdp_clock_distributor_tb
